// ### verilog/acc_regs.v
/*
  Comparator control register bank on AHB-Lite, with edge flag,
  interrupt request, output shaping and shared bus request decode.
  Assumes one AHB-Lite master, word transfers; comparator analog core
  supplies a raw output and an active indication synchronous to hclk.
*/
`timescale 1ns/1ps
`include "acc_map.vh"
module acc_regs (
  input  wire        hclk,            // Bus clock, 50 MHz
  input  wire        hresetn,         // Async reset, active low
  input  wire        hsel,            // Slave select
  input  wire [11:0] haddr,           // Byte address
  input  wire [1:0]  htrans,          // Transfer type
  input  wire        hwrite,          // Write when high
  input  wire [2:0]  hsize,           // Transfer size
  input  wire        hready,          // Bus ready in
  input  wire [31:0] hwdata,          // Write data
  output reg  [31:0] hrdata,          // Read data
  output reg         hreadyout,       // Always ready
  output reg         hresp,           // Always OKAY
  input  wire        cmp_raw,         // Raw comparator output
  input  wire        cmp_active,      // Comparator warmed up and active
  output reg         cmp_out,         // Comparator output to logic
  output reg         pin_out,         // Comparator output to pin
  output reg         irq,             // Interrupt request
  output reg         cmp_enable,      // Enable to analog core
  output reg  [3:0]  supply_onehot,   // Analog, digital, io0, io1
  output reg  [2:0]  range_onehot,    // Full, above half, below half
  output reg         high_accuracy,   // Accuracy mode to core
  output reg  [9:0]  x_bus_req,       // X bus requests
  output reg  [4:0]  y_bus_req,       // Y bus requests
  output reg  [31:0] ctrl_word,       // Control word to analog core
  output reg  [31:0] insel_word       // Input select word to analog core
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [31:0] ctrl_q;
  reg [31:0] insel_q;
  reg        flag_q;
  reg        ien_q;
  reg        prev_q;
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [11:0] addr_q;
  wire       flag_d;
  wire       edge_evt;
  wire       cmp_val;
  wire       take;
  wire       flag_clr;
  wire       flag_set;
  wire [9:0] x_req_w;
  wire [4:0] y_req_w;
  reg  [31:0] rd_mux;
  wire [31:0] ctrl_cur;
  wire [31:0] insel_cur;
  wire        ien_cur;

  // Forward a write in its data phase, so a read right behind it is not stale
  assign ctrl_cur  = (wr_pend_q && addr_q == `ACC_OFF_CTRL)   ? (hwdata & `ACC_CTRL_MASK)  : ctrl_q;
  assign insel_cur = (wr_pend_q && addr_q == `ACC_OFF_INSEL)  ? (hwdata & `ACC_INSEL_MASK) : insel_q;
  assign ien_cur   = (wr_pend_q && addr_q == `ACC_OFF_IRQ_EN) ? hwdata[0] : ien_q;

  // Address phase accepted
  assign take = hsel & hready & htrans[1];

  // Shown output while inactive is the inactive level
  assign cmp_val = cmp_active ? cmp_raw : ctrl_q[`ACC_INACT_BIT]; // R2

  // Edge events gated by the sense bits
  assign edge_evt = (prev_q & ~cmp_val & ctrl_q[`ACC_FALL_BIT]) |
                    (~prev_q & cmp_val & ctrl_q[`ACC_RISE_BIT]); // R1

  assign flag_set = wr_pend_q & (addr_q == `ACC_OFF_FLAG_SET) & hwdata[0];
  assign flag_clr = wr_pend_q & (addr_q == `ACC_OFF_FLAG_CLR) & hwdata[0];
  // Set wins over clear so an edge on the clear cycle is kept
  assign flag_d = edge_evt | flag_set | (flag_q & ~flag_clr); // R1

  // ****************************************************************
  // Bus slave: address phase capture and write data phase
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take)
        addr_q <= {haddr[11:2], 2'h0};
    end
  end

  // Writable fields; reserved bits stay zero whatever is written
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= `ACC_CTRL_RESET;  // R13
      insel_q <= `ACC_INSEL_RESET; // R13
      ien_q   <= 1'b0;
    end else if (wr_pend_q) begin
      if (addr_q == `ACC_OFF_CTRL)
        ctrl_q <= hwdata & `ACC_CTRL_MASK;
      if (addr_q == `ACC_OFF_INSEL)
        insel_q <= hwdata & `ACC_INSEL_MASK;
      if (addr_q == `ACC_OFF_IRQ_EN)
        ien_q <= hwdata[0];
    end
  end

  // Edge tracking and flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      prev_q <= cmp_val;
      flag_q <= flag_d;
    end
  end

  // Read mux on the decoded address phase
  always @* begin
    case ({haddr[11:2], 2'h0})
      `ACC_OFF_CTRL:   rd_mux = ctrl_cur;  // R13
      `ACC_OFF_INSEL:  rd_mux = insel_cur; // R13
      `ACC_OFF_STATUS: rd_mux = {30'h0, cmp_val, cmp_active};
      `ACC_OFF_FLAG:   rd_mux = {31'h0, flag_d};
      `ACC_OFF_IRQ_EN: rd_mux = {31'h0, ien_cur};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  acc_bus_req u_req (
    .pos_sel   (insel_q[`ACC_POS_LSB+7:`ACC_POS_LSB]),
    .neg_sel   (insel_q[`ACC_NEG_LSB+7:`ACC_NEG_LSB]),
    .va_sel    (insel_q[`ACC_VA_LSB+5:`ACC_VA_LSB]),
    .x_dis     (ctrl_q[`ACC_XDIS_BIT]),
    .y_dis     (ctrl_q[`ACC_YDIS_BIT]),
    .v_dis     (ctrl_q[`ACC_VDIS_BIT]),
    .x_req     (x_req_w),
    .y_req_bus (y_req_w)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Read data registered at the address phase so it stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      cmp_out       <= 1'b0;
      pin_out       <= 1'b0;
      irq           <= 1'b0;
      cmp_enable    <= 1'b0;
      supply_onehot <= 4'h1;
      range_onehot  <= 3'h1;
      high_accuracy <= 1'b0;
      x_bus_req     <= 10'h000;
      y_bus_req     <= 5'h00;
      ctrl_word     <= 32'h00000000;
      insel_word    <= 32'h00000000;
    end else begin
      hrdata        <= (take & ~hwrite) ? rd_mux : 32'h00000000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      cmp_out       <= cmp_val;                                    // R2
      pin_out       <= cmp_val ^ ctrl_q[`ACC_INV_BIT];             // R3
      irq           <= flag_d & ien_q;                             // R12
      cmp_enable    <= ctrl_q[`ACC_EN_BIT];
      case (ctrl_q[`ACC_PWR_LSB+2:`ACC_PWR_LSB])                   // R5
        `ACC_PWR_ANALOG:  supply_onehot <= 4'h1;
        `ACC_PWR_DIGITAL: supply_onehot <= 4'h2;
        `ACC_PWR_IO0:     supply_onehot <= 4'h4;
        `ACC_PWR_IO1:     supply_onehot <= 4'h8;
        default:          supply_onehot <= 4'h0;
      endcase
      case (ctrl_q[`ACC_RANGE_LSB+1:`ACC_RANGE_LSB])               // R10
        `ACC_RANGE_FULL:  range_onehot <= 3'h1;
        `ACC_RANGE_ABOVE: range_onehot <= 3'h2;
        `ACC_RANGE_BELOW: range_onehot <= 3'h4;
        default:          range_onehot <= 3'h0;
      endcase
      high_accuracy <= ctrl_q[`ACC_ACC_BIT];
      x_bus_req     <= x_req_w;                                    // R6 R8
      y_bus_req     <= y_req_w;                                    // R6 R7
      ctrl_word     <= ctrl_q;
      insel_word    <= insel_q;
    end
  end

endmodule

// ### verilog/acc_map.vh
/*
  Register map, field positions, reset values and encodings of the
  comparator control register bank.
  Assumes inclusion by the bank and by the bench; definitions only.
*/
// How it works
// R1: Edge flag sets on falling edge if falling sense set, rising likewise.
// R2: While comparator inactive, output shows the inactive level bit.
// R3: Pin output is inverted when pin invert bit is set.
// R4: Software changes supply select only while comparator enable is clear.
// R5: Supply select decodes 0 analog, 1 digital, 2 first I/O, 4 second I/O.
// R6: Divider bus master disable stops requesting the divider-selected bus.
// R7: Y bus master disable stops requesting Y bus from input selects.
// R8: X bus master disable stops requesting X bus from input selects.
// R9: Software sets accuracy high when scanning fast or oscillating.
// R10: Input range decodes 0 full, 1 above half, 2 below half supply.
// R11: Software writes zero to every reserved bit.
// R12: Interrupt request raised while edge flag and its enable are set.
// R13: Reset loads bias level seven, all else zero; reads return stored fields.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACC_OFF_CTRL      12'h000
`define ACC_OFF_INSEL     12'h004
`define ACC_OFF_STATUS    12'h008
`define ACC_OFF_FLAG      12'h00c
`define ACC_OFF_FLAG_SET  12'h010
`define ACC_OFF_FLAG_CLR  12'h014
`define ACC_OFF_IRQ_EN    12'h018

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define ACC_CTRL_MASK     32'hbf3cf70d
`define ACC_CTRL_RESET    32'h07000000
`define ACC_INSEL_MASK    32'h757fffff
`define ACC_INSEL_RESET   32'h00000000

// ****************************************************************
// Control field positions
// ****************************************************************
`define ACC_EN_BIT        0
`define ACC_INACT_BIT     2
`define ACC_INV_BIT       3
`define ACC_XDIS_BIT      8
`define ACC_YDIS_BIT      9
`define ACC_VDIS_BIT      10
`define ACC_PWR_LSB       12
`define ACC_ACC_BIT       15
`define ACC_RANGE_LSB     18
`define ACC_RISE_BIT      20
`define ACC_FALL_BIT      21

// ****************************************************************
// Input select field positions
// ****************************************************************
`define ACC_POS_LSB       0
`define ACC_NEG_LSB       8
`define ACC_VA_LSB        16

// ****************************************************************
// Encodings
// ****************************************************************
`define ACC_PWR_ANALOG    3'h0
`define ACC_PWR_DIGITAL   3'h1
`define ACC_PWR_IO0       3'h2
`define ACC_PWR_IO1       3'h4
`define ACC_RANGE_FULL    2'h0
`define ACC_RANGE_ABOVE   2'h1
`define ACC_RANGE_BELOW   2'h2

`endif

// ### verilog/acc_bus_req.v
/*
  Shared analog bus request decode for the comparator.
  Assumes input select codes per the register map; purely combinational.
*/
`timescale 1ns/1ps
module acc_bus_req (
  input  wire [7:0] pos_sel,     // Positive input select
  input  wire [7:0] neg_sel,     // Negative input select
  input  wire [5:0] va_sel,      // Divider source select
  input  wire       x_dis,       // X bus master disable
  input  wire       y_dis,       // Y bus master disable
  input  wire       v_dis,       // Divider bus master disable
  output wire [9:0] x_req,       // X bus requests, one per bus 0..4 (even bits)
  output wire [4:0] y_req_bus    // Y bus requests per bus
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Bus number 0..4 of an input code, 7 when not a bus channel
  function [2:0] bus_of;
    input [7:0] code;
    begin
      if (code < 8'ha0)
        bus_of = (code < 8'h20) ? 3'h0 : code[7:5];
      else
        bus_of = 3'h7;
    end
  endfunction

  // Is the code a Y-bus channel
  function is_y;
    input [7:0] code;
    begin
      if (code < 8'h20)
        is_y = code[4];
      else if (code[7:5] == 3'h1 || code[7:5] == 3'h3)
        is_y = code[0];
      else
        is_y = ~code[0];
    end
  endfunction

  // Per-bus request: mask the X or Y half by the disable bits
  function [1:0] req_of;
    input [7:0] code;
    input       xd;
    input       yd;
    begin
      req_of = 2'h0;
      if (bus_of(code) != 3'h7) begin
        if (is_y(code))
          req_of = {~yd, 1'b0};
        else
          req_of = {1'b0, ~xd};
      end
    end
  endfunction

  wire [7:0] va_code;
  // Divider codes 0x01..0x1f are bus 2 channel code-1, 0x20..0x3f are bus 1 as is
  assign va_code = (va_sel == 6'h00) ? 8'hff :
                   (va_sel[5] ? {2'h0, va_sel} : ({3'h2, va_sel[4:0]} - 8'h01));

  genvar b;
  generate
    for (b = 0; b < 5; b = b + 1) begin : g_bus
      wire [1:0] rp;
      wire [1:0] rn;
      wire [1:0] rv;
      assign rp = (bus_of(pos_sel) == b) ? req_of(pos_sel, x_dis, y_dis) : 2'h0; // R7 R8
      assign rn = (bus_of(neg_sel) == b) ? req_of(neg_sel, x_dis, y_dis) : 2'h0; // R7 R8
      assign rv = (bus_of(va_code) == b) ? req_of(va_code, v_dis, v_dis) : 2'h0; // R6
      assign x_req[2*b]   = rp[0] | rn[0] | rv[0];
      assign x_req[2*b+1] = 1'b0;
      assign y_req_bus[b] = rp[1] | rn[1] | rv[1];
    end
  endgenerate

endmodule

// ### dv/acc_regs_props.sv
/* Output checker for the comparator register bank.
   Assumes bind to acc_regs; one clock, async active-low reset. */
`timescale 1ns/1ps
module acc_props (
  input wire        hclk,          // Clock
  input wire        hresetn,       // Reset, low
  input wire        cmp_raw,       // Raw level
  input wire        cmp_active,    // Core active
  input wire        cmp_out,       // Shaped level
  input wire        pin_out,       // Pin level
  input wire        irq,           // Interrupt
  input wire [3:0]  supply_onehot, // Supply decode
  input wire [2:0]  range_onehot,  // Range decode
  input wire        high_accuracy, // Accuracy
  input wire [9:0]  x_bus_req,     // X requests
  input wire [4:0]  y_bus_req,     // Y requests
  input wire [31:0] ctrl_word,     // Control copy
  input wire [31:0] insel_word     // Select copy
);
  // ****
  // Settled-register history
  // ****
  reg [31:0] c1_q, c2_q, i1_q, i2_q;
  // Decodes judged only after two quiet cycles, since outputs lag a cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {c1_q, c2_q, i1_q, i2_q} <= 128'h0;
    else {c2_q, c1_q, i2_q, i1_q} <= {c1_q, ctrl_word, i1_q, insel_word};
  end
  wire       st    = ctrl_word == c1_q && c1_q == c2_q && insel_word == i1_q && i1_q == i2_q;
  wire [2:0] pw    = ctrl_word[14:12];
  wire [1:0] rg    = ctrl_word[19:18];
  wire [3:0] sup_e = pw == 3'h0 ? 4'h1 : pw == 3'h1 ? 4'h2 : pw == 3'h2 ? 4'h4 : pw == 3'h4 ? 4'h8 : 4'h0;
  wire [2:0] rng_e = rg == 2'h3 ? 3'h0 : 3'h1 << rg;
  wire       nb    = insel_word[7:0] >= 8'ha0 && insel_word[15:8] >= 8'ha0;
  wire       va0   = insel_word[21:16] == 6'h0;
  // ****
  // Properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ACTIVE: assert property ($past(hresetn) && $past(cmp_active) |-> cmp_out == $past(cmp_raw))
    else $error("active output wrong");
  AST_INACT: assert property ($past(hresetn) && $past(!cmp_active) && st |-> cmp_out == ctrl_word[2])
    else $error("inactive level wrong");
  AST_INV: assert property (st && $stable(cmp_out) |-> pin_out == (cmp_out ^ ctrl_word[3]))
    else $error("pin invert wrong");
  AST_SUPPLY: assert property (st |-> supply_onehot == sup_e)
    else $error("supply decode wrong");
  AST_RANGE: assert property (st |-> range_onehot == rng_e)
    else $error("range decode wrong");
  AST_ACCUR: assert property (st |-> high_accuracy == ctrl_word[15])
    else $error("accuracy wrong");
  AST_XDIS: assert property (st && ctrl_word[8] && (ctrl_word[10] || va0) |-> x_bus_req == 10'h0)
    else $error("x request while disabled");
  AST_YDIS: assert property (st && ctrl_word[9] && (ctrl_word[10] || va0) |-> y_bus_req == 5'h0)
    else $error("y request while disabled");
  AST_VDIS: assert property (st && ctrl_word[10] && nb |-> x_bus_req == 10'h0 && y_bus_req == 5'h0)
    else $error("divider request while disabled");
  // Main scenarios reached
  cover property ($rose(irq));
  cover property (x_bus_req != 10'h0);
  cover property (st && ctrl_word[3] && pin_out);
endmodule
bind acc_regs acc_props acc_props_inst (.hclk, .hresetn, .cmp_raw, .cmp_active, .cmp_out, .pin_out, .irq,
  .supply_onehot, .range_onehot, .high_accuracy, .x_bus_req, .y_bus_req, .ctrl_word, .insel_word);

// ### dv/comparator_control_registers_tb_top.sv
/* Self-checking bench for the comparator register bank.
   Assumes acc_regs with the acc_map.vh map and zero wait states. */
`timescale 1ns/1ps
`include "acc_map.vh"
module comparator_control_registers_tb_top;
  reg         hclk, hresetn, hsel, hwrite, cmp_raw, cmp_active;
  reg  [11:0] haddr;
  reg  [1:0]  htrans;
  reg  [31:0] hwdata, rd, ctrl_m, insel_m;
  integer     fails, samples_checked, seed, i;
  wire [31:0] hrdata, ctrl_word, insel_word;
  wire        hreadyout, hresp, cmp_out, pin_out, irq, cmp_enable, high_accuracy;
  wire [3:0]  supply_onehot;
  wire [2:0]  range_onehot;
  wire [9:0]  x_bus_req;
  wire [4:0]  y_bus_req;
  acc_regs acc_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .cmp_raw, .cmp_active, .cmp_out, .pin_out, .irq, .cmp_enable,
    .supply_onehot, .range_onehot, .high_accuracy, .x_bus_req, .y_bus_req, .ctrl_word, .insel_word);
  // ****
  // Tasks
  // ****
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Single word transfer; the one slave's ready is the bus ready
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d); bus(1'b1, a, d); endtask
  task rdchk(input [11:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rd, e);
      chk(hresp, 1'b0);
    end
  endtask
  // Outputs lag the registers, so give them time to land
  task settle; begin repeat (3) @(posedge hclk); #1; end endtask
  task busreq(input [31:0] c, input [31:0] s, input [9:0] ex, input [4:0] ey);
    begin
      wr(`ACC_OFF_CTRL, c);
      wr(`ACC_OFF_INSEL, s);
      settle;
      chk(x_bus_req, ex);
      chk(y_bus_req, ey);
    end
  endtask
  function [3:0] sup(input [2:0] c);
    sup = c == 3'h0 ? 4'h1 : c == 3'h1 ? 4'h2 : c == 3'h2 ? 4'h4 : c == 3'h4 ? 4'h8 : 4'h0;
  endfunction
  task give_verdict;
    begin
      $display("checked %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ****
  // Clock, watchdog, sequence
  // ****
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Whole run needs a few hundred cycles at most
  initial begin
    #200000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    seed = 94;
    {hresetn, hsel, hwrite, cmp_raw, cmp_active, haddr, htrans, hwdata} = 51'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`ACC_OFF_CTRL, 32'h07000000);
    rdchk(`ACC_OFF_INSEL, 32'h0);
    rdchk(12'h030, 32'h0);
    $display("reset test done");
    // Every supply and range code, inactive level and invert pairs
    for (i = 0; i < 8; i = i + 1) begin
      ctrl_m = ($random(seed) & `ACC_CTRL_MASK & 32'hfff38ff2) | (i << 12) | (i % 4 << 18) | (i % 4 << 2);
      insel_m = $random(seed) & `ACC_INSEL_MASK;
      wr(`ACC_OFF_CTRL, ctrl_m);
      wr(`ACC_OFF_INSEL, insel_m);
      rdchk(`ACC_OFF_CTRL, ctrl_m);
      rdchk(`ACC_OFF_INSEL, insel_m);
      settle;
      chk(supply_onehot, sup(i));
      chk(range_onehot, i % 4 == 3 ? 3'h0 : 3'h1 << i % 4);
      chk(high_accuracy, ctrl_m[15]);
      chk(cmp_out, ctrl_m[2]);
      chk(pin_out, ctrl_m[2] ^ ctrl_m[3]);
    end
    // Enable raised and dropped with the supply field left as it stands
    wr(`ACC_OFF_CTRL, ctrl_m | 32'h1);
    settle;
    chk(cmp_enable, 1'b1);
    chk(ctrl_word, ctrl_m | 32'h1);
    chk(insel_word, insel_m);
    wr(`ACC_OFF_CTRL, ctrl_m);
    $display("decode test done");
    cmp_active <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      cmp_raw <= $random(seed);
      settle;
      chk(cmp_out, cmp_raw);
      chk(pin_out, cmp_raw ^ ctrl_m[3]);
      rdchk(`ACC_OFF_STATUS, {30'h0, cmp_raw, 1'b1});
    end
    $display("active test done");
    // Each sense pairing against both edge directions
    wr(`ACC_OFF_IRQ_EN, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`ACC_OFF_CTRL, 32'h07000000 | (i << 20));
      cmp_raw <= 1'b0;
      settle;
      wr(`ACC_OFF_FLAG_CLR, 32'h1);
      cmp_raw <= 1'b1;
      settle;
      rdchk(`ACC_OFF_FLAG, i % 2);
      chk(irq, i % 2);
      wr(`ACC_OFF_FLAG_CLR, 32'h1);
      cmp_raw <= 1'b0;
      settle;
      rdchk(`ACC_OFF_FLAG, i / 2);
      chk(irq, i / 2);
    end
    wr(`ACC_OFF_IRQ_EN, 32'h0);
    wr(`ACC_OFF_FLAG_SET, 32'h1);
    rdchk(`ACC_OFF_FLAG, 32'h1);
    chk(irq, 1'b0);
    $display("edge test done");
    busreq(32'h07000000, 32'h0000ff20, 10'h004, 5'h00);
    busreq(32'h07000100, 32'h0000ff20, 10'h000, 5'h00);
    busreq(32'h07000000, 32'h000021ff, 10'h000, 5'h02);
    busreq(32'h07000200, 32'h000021ff, 10'h000, 5'h00);
    busreq(32'h07000000, 32'h0020ffff, 10'h004, 5'h00);
    busreq(32'h07000400, 32'h0020ffff, 10'h000, 5'h00);
    $display("bus request test done");
    give_verdict;
  end
endmodule
